/* hw/rtc_cfg.svh */
/*
 * Offsets, field positions, reset values and timing counts of the rail
 * trim controller. Definitions only; included by rtc_pkg.sv, rtc_top.sv and two of the three dv files.
 */
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

`define RTC_ADDR_W          8
`define RTC_DATA_W          16
`define RTC_TRIM_W          8
`define RTC_MEAS_W          12
`define RTC_CHAN_W          4

// Per-channel block: byte address = channel * 8 + offset
`define RTC_OFF_CFG         3'h0
`define RTC_OFF_TRIM_INIT   3'h1
`define RTC_OFF_TRIM_HIGH   3'h2
`define RTC_OFF_TRIM_LOW    3'h3
`define RTC_OFF_TGT_NOM     3'h4
`define RTC_OFF_TGT_HIGH    3'h5
`define RTC_OFF_TGT_LOW     3'h6
`define RTC_OFF_STAT        3'h7

// Global registers
`define RTC_GLB_CTRL        8'h80
`define RTC_GLB_CMD         8'h81
`define RTC_GLB_STAT        8'h82

// Field positions
`define RTC_CFG_MODE_LSB    0
`define RTC_CFG_DIGITAL_BIT 2
`define RTC_CTRL_INIT_BIT   0
`define RTC_CMD_SEL_LSB     0
`define RTC_CMD_CHAN_LSB    4

// Reset values
`define RTC_TRIM_INIT_RST   8'h80
`define RTC_TRIM_HIGH_RST   8'hA0
`define RTC_TRIM_LOW_RST    8'h60
`define RTC_TGT_NOM_RST     12'h800
`define RTC_TGT_HIGH_RST    12'h880
`define RTC_TGT_LOW_RST     12'h780

// Timing: one control loop pass every 2000 us at 25000 kHz
`define RTC_CLK_KHZ         25000
`define RTC_SCAN_US         2000
`define RTC_SCAN_CYCLES     ((`RTC_SCAN_US * `RTC_CLK_KHZ) / 1000)

// PMBus OPERATION command and its data bytes
`define RTC_PMBUS_OPERATION 8'h01
`define RTC_OP_NOMINAL      8'h80
`define RTC_OP_MARGIN_LOW   8'h98
`define RTC_OP_MARGIN_HIGH  8'hA8

`endif

/* hw/rtc_pkg.sv */
/*
 * Types of the rail trim controller: modes, margin selections, loop states
 * and the packed carriers. Assumes rtc_cfg.svh for widths.
 */
`include "rtc_cfg.svh"

package rtc_pkg;

    typedef enum logic [1:0] {
        RTC_TRIM_OFF    = 2'h0,
        RTC_TRIM_OPEN   = 2'h1,
        RTC_TRIM_CLOSED = 2'h2
    } rtc_mode_type;

    typedef enum logic [1:0] {
        RTC_MARGIN_CENTER = 2'h0,
        RTC_MARGIN_HIGH   = 2'h1,
        RTC_MARGIN_LOW    = 2'h2
    } rtc_margin_type;

    typedef enum logic [1:0] {
        RTC_ST_HOLD  = 2'b01,
        RTC_ST_TRACK = 2'b10
    } rtc_loop_type;

    typedef struct packed {
        logic         digital_rail;
        rtc_mode_type mode;
    } rtc_chan_cfg_type;

    typedef struct packed {
        logic                    valid;
        logic [`RTC_CHAN_W-1:0]  chan;
        logic [7:0]              code;
        logic [7:0]              data;
    } rtc_pmbus_req_type;

endpackage

/* hw/rtc_pwm.sv */
/*
 * Free-running PWM used as a DAC for one trim channel.
 * Assumes an external low-pass filter turns the pulse train into a level.
 */
module rtc_pwm #(
    parameter int W = 8
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] duty,
    output logic              pwm_out
);

    logic [W-1:0] count;

    // Duty of all ones gives (2^W-1)/2^W; a code of zero holds the pin low
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count   <= '0;
            pwm_out <= 1'b0;
        end else begin
            count   <= count + 1'b1;
            pwm_out <= (count < duty);
        end
    end

endmodule

/* hw/rtc_top.sv */
/*
 * Rail trim controller: per-channel PWM trim with disabled, open-loop and
 * closed-loop modes, margin commands and PMBus OPERATION for digital rails.
 * Assumes rail_meas and rails_powered come from logic on core_clk.
 */
`include "rtc_cfg.svh"

module rtc_top
    import rtc_pkg::*;
#(
    parameter int N           = 4,
    parameter int SCAN_CYCLES = `RTC_SCAN_CYCLES
) (
    input  wire logic                               core_clk,
    input  wire logic                               arst_n,
    input  wire logic [`RTC_ADDR_W-1:0]             reg_addr,
    input  wire logic [`RTC_DATA_W-1:0]             reg_wdata,
    input  wire logic                               reg_wr,
    input  wire logic                               reg_rd,
    output logic      [`RTC_DATA_W-1:0]             reg_rdata,
    input  wire logic [N-1:0][`RTC_MEAS_W-1:0]      rail_meas,
    input  wire logic                               rails_powered,
    output logic      [N-1:0]                       trim_pwm,
    output rtc_pkg::rtc_pmbus_req_type              pmbus_req
);
    import rtc_pkg::*;

    localparam int TW = `RTC_TRIM_W;
    localparam int MW = `RTC_MEAS_W;
    localparam int DW = `RTC_DATA_W;
    localparam int SW = $clog2(SCAN_CYCLES);

    function automatic logic is_chan(input logic [`RTC_ADDR_W-1:0] a);
        return !a[`RTC_ADDR_W-1];
    endfunction

    function automatic logic [`RTC_CHAN_W-1:0] chan_of(input logic [`RTC_ADDR_W-1:0] a);
        return a[6:3];
    endfunction

    function automatic logic [2:0] off_of(input logic [`RTC_ADDR_W-1:0] a);
        return a[2:0];
    endfunction

    // Reset release through two flops
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Loop pass divider
    logic [SW-1:0] scan_count;
    logic          scan_tick;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_count <= '0;
            scan_tick  <= 1'b0;
        end else begin
            scan_tick  <= (scan_count == SW'(SCAN_CYCLES - 1));
            scan_count <= (scan_count == SW'(SCAN_CYCLES - 1)) ? '0 : scan_count + 1'b1;
        end
    end

    // Loop state: closed-loop adjustment waits for every sequenced rail
    rtc_loop_type loop_state;
    rtc_loop_type next_loop_state;

    always_comb begin
        next_loop_state = loop_state;
        unique case (loop_state)
            RTC_ST_HOLD:  if (rails_powered) next_loop_state = RTC_ST_TRACK;
            RTC_ST_TRACK: if (!rails_powered) next_loop_state = RTC_ST_HOLD;
            default:      next_loop_state = RTC_ST_HOLD;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            loop_state <= RTC_ST_HOLD;
        end else begin
            loop_state <= next_loop_state;
        end
    end

    // Decode of the register port
    wire                    wr_chan  = reg_wr && is_chan(reg_addr);
    wire [`RTC_CHAN_W-1:0]  wr_ch    = chan_of(reg_addr);
    wire [2:0]              wr_off   = off_of(reg_addr);
    wire                    init_hit = reg_wr && (reg_addr == `RTC_GLB_CTRL)
                                       && reg_wdata[`RTC_CTRL_INIT_BIT];
    wire                    cmd_wr   = reg_wr && (reg_addr == `RTC_GLB_CMD);
    wire [1:0]              cmd_raw  = reg_wdata[`RTC_CMD_SEL_LSB +: 2];
    wire [`RTC_CHAN_W-1:0]  cmd_ch   = reg_wdata[`RTC_CMD_CHAN_LSB +: `RTC_CHAN_W];
    // Selection code 3 is not a command and is dropped
    wire                    cmd_hit  = cmd_wr && (cmd_raw != 2'h3)
                                       && (int'(cmd_ch) < N);
    wire rtc_margin_type    cmd_sel  = rtc_margin_type'(cmd_raw);
    wire                    tracking = (loop_state == RTC_ST_TRACK);

    rtc_chan_cfg_type [N-1:0]       cfg;
    logic [N-1:0][TW-1:0]           trim_init;
    logic [N-1:0][TW-1:0]           trim_high;
    logic [N-1:0][TW-1:0]           trim_low;
    logic [N-1:0][MW-1:0]           tgt_nom;
    logic [N-1:0][MW-1:0]           tgt_high;
    logic [N-1:0][MW-1:0]           tgt_low;
    rtc_margin_type [N-1:0]         margin_sel;
    logic [N-1:0][TW-1:0]           trim_code;
    logic [N-1:0][MW-1:0]           target;
    logic [N-1:0][DW-1:0]           chan_word;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gen_chan
            wire wr_me  = wr_chan && (int'(wr_ch) == g);
            wire cmd_me = cmd_hit && (int'(cmd_ch) == g);
            wire analog = !cfg[g].digital_rail;

            // Settings of this channel alone
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    cfg[g]       <= '{digital_rail: 1'b0, mode: RTC_TRIM_OFF};
                    trim_init[g] <= `RTC_TRIM_INIT_RST;
                    trim_high[g] <= `RTC_TRIM_HIGH_RST;
                    trim_low[g]  <= `RTC_TRIM_LOW_RST;
                    tgt_nom[g]   <= `RTC_TGT_NOM_RST;
                    tgt_high[g]  <= `RTC_TGT_HIGH_RST;
                    tgt_low[g]   <= `RTC_TGT_LOW_RST;
                end else if (wr_me) begin
                    unique case (wr_off)
                        `RTC_OFF_CFG: begin
                            cfg[g].mode         <= rtc_mode_type'(
                                reg_wdata[`RTC_CFG_MODE_LSB +: 2]);
                            cfg[g].digital_rail <= reg_wdata[`RTC_CFG_DIGITAL_BIT];
                        end
                        `RTC_OFF_TRIM_INIT: trim_init[g] <= reg_wdata[TW-1:0];
                        `RTC_OFF_TRIM_HIGH: trim_high[g] <= reg_wdata[TW-1:0];
                        `RTC_OFF_TRIM_LOW:  trim_low[g]  <= reg_wdata[TW-1:0];
                        `RTC_OFF_TGT_NOM:   tgt_nom[g]   <= reg_wdata[MW-1:0];
                        `RTC_OFF_TGT_HIGH:  tgt_high[g]  <= reg_wdata[MW-1:0];
                        `RTC_OFF_TGT_LOW:   tgt_low[g]   <= reg_wdata[MW-1:0];
                        default: ;
                    endcase
                end
            end

            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    margin_sel[g] <= RTC_MARGIN_CENTER;
                end else if (cmd_me) begin
                    margin_sel[g] <= cmd_sel;
                end
            end

            assign target[g] = (margin_sel[g] == RTC_MARGIN_HIGH) ? tgt_high[g] :
                               (margin_sel[g] == RTC_MARGIN_LOW)  ? tgt_low[g]  :
                                                                     tgt_nom[g];

            // Disabled and digital rails never reach these branches
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    trim_code[g] <= `RTC_TRIM_INIT_RST;
                end else if (cfg[g].mode == RTC_TRIM_OFF || !analog) begin
                    trim_code[g] <= trim_code[g];
                end else if (init_hit) begin
                    trim_code[g] <= trim_init[g];
                end else if (cfg[g].mode == RTC_TRIM_OPEN) begin
                    if (cmd_me && cmd_sel == RTC_MARGIN_HIGH) begin
                        trim_code[g] <= trim_high[g];
                    end else if (cmd_me && cmd_sel == RTC_MARGIN_LOW) begin
                        trim_code[g] <= trim_low[g];
                    end
                end else if (cfg[g].mode == RTC_TRIM_CLOSED && tracking && scan_tick) begin
                    // One sample per pass against the selected target
                    if (rail_meas[g] > target[g] && trim_code[g] != {TW{1'b1}}) begin
                        trim_code[g] <= trim_code[g] + 1'b1;
                    end else if (rail_meas[g] < target[g] && trim_code[g] != '0) begin
                        trim_code[g] <= trim_code[g] - 1'b1;
                    end
                end
            end

            rtc_pwm #(
                .W        (TW)
            ) u_pwm (
                .core_clk (core_clk),
                .rst_n    (rst_n),
                .duty     (trim_code[g]),
                .pwm_out  (trim_pwm[g])
            );

            assign chan_word[g] =
                (off_of(reg_addr) == `RTC_OFF_CFG)       ? DW'({cfg[g].digital_rail,
                                                               cfg[g].mode}) :
                (off_of(reg_addr) == `RTC_OFF_TRIM_INIT) ? DW'(trim_init[g]) :
                (off_of(reg_addr) == `RTC_OFF_TRIM_HIGH) ? DW'(trim_high[g]) :
                (off_of(reg_addr) == `RTC_OFF_TRIM_LOW)  ? DW'(trim_low[g])  :
                (off_of(reg_addr) == `RTC_OFF_TGT_NOM)   ? DW'(tgt_nom[g])   :
                (off_of(reg_addr) == `RTC_OFF_TGT_HIGH)  ? DW'(tgt_high[g])  :
                (off_of(reg_addr) == `RTC_OFF_TGT_LOW)   ? DW'(tgt_low[g])   :
                                                           DW'({margin_sel[g], trim_code[g]});
        end
    endgenerate

    // Read path: channel blocks beyond N and unmapped globals read zero
    wire [`RTC_CHAN_W-1:0] rd_ch   = chan_of(reg_addr);
    wire                   rd_chan = is_chan(reg_addr) && (int'(rd_ch) < N);
    wire [DW-1:0]          glb_word =
        (reg_addr == `RTC_GLB_STAT) ? DW'({rails_powered, loop_state}) : '0;
    wire [DW-1:0]          rd_word = rd_chan ? chan_word[rd_ch] : glb_word;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_word : '0;
        end
    end

    // Digital rails not in RTC_TRIM_OFF: a margin command becomes one OPERATION request
    wire    cmd_digital = cmd_hit && cfg[cmd_ch].digital_rail
                          && (cfg[cmd_ch].mode != RTC_TRIM_OFF);
    wire [7:0] op_data  = (cmd_sel == RTC_MARGIN_HIGH) ? `RTC_OP_MARGIN_HIGH :
                          (cmd_sel == RTC_MARGIN_LOW)  ? `RTC_OP_MARGIN_LOW  :
                                                         `RTC_OP_NOMINAL;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pmbus_req <= '0;
        end else begin
            pmbus_req.valid <= cmd_digital;
            if (cmd_digital) begin
                pmbus_req.chan <= cmd_ch;
                pmbus_req.code <= `RTC_PMBUS_OPERATION;
                pmbus_req.data <= op_data;
            end
        end
    end

endmodule

/* dv/rtc_properties.sv */
/*
 * Port-level checks of the rail trim controller.
 * Assumes it is bound to rtc_top with the same N.
 */
`include "rtc_cfg.svh"

module rtc_properties
    import rtc_pkg::*;
#(
    parameter int N = 4
) (
    input wire logic                          core_clk,
    input wire logic                          arst_n,
    input wire logic [`RTC_ADDR_W-1:0]        reg_addr,
    input wire logic [`RTC_DATA_W-1:0]        reg_wdata,
    input wire logic                          reg_wr,
    input wire logic                          reg_rd,
    input wire logic [`RTC_DATA_W-1:0]        reg_rdata,
    input wire logic [N-1:0][`RTC_MEAS_W-1:0] rail_meas,
    input wire logic                          rails_powered,
    input wire logic [N-1:0]                  trim_pwm,
    input wire rtc_pkg::rtc_pmbus_req_type    pmbus_req
);
    wire logic hole_read = reg_rd && (reg_addr > 8'h82 ||
                           (reg_addr < 8'h80 && int'(reg_addr[6:3]) >= N));

    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_cmd_write;
        reg_wr && reg_addr == `RTC_GLB_CMD;
    endsequence
    sequence s_pmbus_pulse;
        s_cmd_write ##1 pmbus_req.valid;
    endsequence

    a_pmbus_code_fixed: assert property (s_pmbus_pulse |-> pmbus_req.code == 8'h01)
        else $error("operation code is not 0x01");
    a_pmbus_has_cause: assert property (pmbus_req.valid |->
        $past(reg_wr && reg_addr == `RTC_GLB_CMD))
        else $error("pmbus pulse without a command write");
    a_pmbus_chan_match: assert property (s_pmbus_pulse |->
        pmbus_req.chan == $past(reg_wdata[7:4]))
        else $error("pmbus channel differs from command");
    a_pmbus_data_map: assert property (s_pmbus_pulse |-> pmbus_req.data ==
        ($past(reg_wdata[1:0]) == 2'h1 ? 8'hA8 : $past(reg_wdata[1:0]) == 2'h2 ? 8'h98 : 8'h80))
        else $error("pmbus data does not match margin");
    a_pmbus_fields_hold: assert property (!pmbus_req.valid |->
        $stable({pmbus_req.chan, pmbus_req.code, pmbus_req.data}))
        else $error("pmbus fields moved without a pulse");
    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside the answer cycle");
    a_loop_state_read: assert property (reg_rd && reg_addr == `RTC_GLB_STAT |=>
        $onehot(reg_rdata[1:0]) && reg_rdata[2] == $past(rails_powered))
        else $error("loop status word malformed");
    a_hole_reads_zero: assert property (hole_read |=> reg_rdata == 16'h0000)
        else $error("unmapped read returned data");
endmodule

/* dv/rtc_rail_model.sv */
/*
 * Regulator side: reports rail voltages set by the bench, powers up after a
 * delay, and filters each PWM over 256 cycles into a trim level.
 */
module rtc_rail_model #(
    parameter int N        = 4,
    parameter int UP_DELAY = 20
) (
    input  wire logic                core_clk,
    input  wire logic [N-1:0]        trim_pwm,
    input  wire logic                power_req,
    input  wire logic [N-1:0][11:0]  meas_set,
    output logic      [N-1:0][11:0]  rail_meas,
    output logic                     rails_powered,
    output logic      [N-1:0][7:0]   trim_level
);
    logic [7:0]       phase  = 8'h00;
    logic [N-1:0][7:0] acc   = '0;
    int               up_cnt = 0;

    // Series resistor sized so trim cannot push a rail out of range; the bench sets levels
    assign rail_meas = meas_set;

    // Box filter over one PWM period stands in for the board RC network
    always_ff @(posedge core_clk) begin
        phase <= phase + 8'h01;
        for (int c = 0; c < N; c++) begin
            acc[c] <= (phase == 8'hFF) ? 8'h00 : acc[c] + 8'(trim_pwm[c]);
            if (phase == 8'hFF) begin
                trim_level[c] <= acc[c] + 8'(trim_pwm[c]);
            end
        end
        up_cnt        <= power_req ? up_cnt + 1 : 0;
        rails_powered <= power_req && up_cnt >= UP_DELAY;
    end
endmodule

/* dv/test_rail_trim_controller.sv */
/*
 * Self-checking bench of the rail trim controller with a regulator model.
 * Assumes hw/ on the include path; scan shortened to 16 cycles.
 */
`include "rtc_cfg.svh"

module test_rail_trim_controller;
    timeunit 1ns;
    timeprecision 1ps;
    import rtc_pkg::*;
    localparam int N = 4;
    localparam int SCAN = 16;
    logic              core_clk  = 1'b0;
    logic              arst_n    = 1'b0;
    logic [7:0]        reg_addr  = 8'h00;
    logic [15:0]       reg_wdata = 16'h0000;
    logic              reg_wr    = 1'b0;
    logic              reg_rd    = 1'b0;
    logic              power_req = 1'b0;
    logic [N-1:0][11:0] meas_set = '0;
    logic [15:0]       reg_rdata, d, e;
    logic [N-1:0][11:0] rail_meas;
    logic              rails_powered;
    logic [N-1:0]      trim_pwm;
    logic [N-1:0][7:0] trim_level;
    rtc_pmbus_req_type pmbus_req;
    logic [7:0]        hi, lo, ini;
    logic [1:0]        osel [3] = '{2'd1, 2'd0, 2'd2};
    logic [15:0]       rst_tab [8] = '{16'h0000, {8'h00, `RTC_TRIM_INIT_RST},
        {8'h00, `RTC_TRIM_HIGH_RST}, {8'h00, `RTC_TRIM_LOW_RST}, {4'h0, `RTC_TGT_NOM_RST},
        {4'h0, `RTC_TGT_HIGH_RST}, {4'h0, `RTC_TGT_LOW_RST}, 16'h0080};
    int                failures = 0;
    int                check_count = 0;
    integer            seed = 32'hb272;

    rtc_top #(.N(N), .SCAN_CYCLES(SCAN)) DUT (.core_clk(core_clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rail_meas(rail_meas), .rails_powered(rails_powered),
        .trim_pwm(trim_pwm), .pmbus_req(pmbus_req));
    rtc_rail_model #(.N(N)) u_rail (.core_clk(core_clk), .trim_pwm(trim_pwm),
        .power_req(power_req), .meas_set(meas_set), .rail_meas(rail_meas),
        .rails_powered(rails_powered), .trim_level(trim_level));

    initial begin
        forever #20 core_clk = ~core_clk;
    end

    task automatic report_and_stop;
        if (failures == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_req(input rtc_pmbus_req_type exp, input rtc_pmbus_req_type got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected pmbus request expected %h seen %h", exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        @(negedge core_clk);
        v = reg_rdata;
    endtask

    function automatic logic [7:0] exp_track(logic [7:0] c, logic [11:0] m, logic [1:0] s, int k);
        int t;
        int v;
        t = (s == 2'd1) ? `RTC_TGT_HIGH_RST : (s == 2'd2) ? `RTC_TGT_LOW_RST : `RTC_TGT_NOM_RST;
        v = (m > t) ? c + k : (m < t) ? c - k : c;
        return (v > 255) ? 8'hFF : (v < 0) ? 8'h00 : 8'(v);
    endfunction

    // Two status reads exactly k scan periods apart see exactly k loop passes
    task automatic track(input logic [7:0] init, input logic [11:0] m, input logic [1:0] s,
                         input int k);
        meas_set[2] <= m;
        wr(8'h11, {8'h00, init});
        wr(`RTC_GLB_CTRL, 16'h0001);
        wr(`RTC_GLB_CMD, {8'h00, 4'h2, 2'b00, s});
        rd(8'h17, d);
        repeat (SCAN * k - 2) @(posedge core_clk);
        rd(8'h17, e);
        chk_word("closed loop status", {6'h00, s, exp_track(d[7:0], m, s, k)}, e);
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            rd(8'(i), d);
            chk_word("channel register", rst_tab[i], d);
        end
        rd(`RTC_GLB_STAT, d);
        chk_word("loop status", 16'h0001, d);
        rd(8'h90, d);
        chk_word("hole read", 16'h0000, d);
        rd(8'h20, d);
        chk_word("absent channel", 16'h0000, d);
        meas_set[0] <= 12'($random(seed));
        wr(8'h10, 16'h0002);
        meas_set[2] <= 12'hFFF;
        repeat (SCAN * 3) @(posedge core_clk);
        rd(8'h17, d);
        chk_word("code before power up", 16'h0080, d);
        power_req <= 1'b1;
        repeat (40) @(posedge core_clk);
        rd(`RTC_GLB_STAT, d);
        chk_word("loop status", 16'h0006, d);
        track(8'hFE, 12'hFFF, 2'd0, 4);
        track(8'h01, 12'h000, 2'd0, 4);
        track(8'h40, 12'h800, 2'd0, 2);
        for (int i = 0; i < 6; i++) begin
            track(8'h10 + 8'($unsigned($random(seed)) % 224),
                  12'h781 + 12'($unsigned($random(seed)) % 127), 2'(i % 3), 3);
        end
        {hi, lo, ini} = 24'($random(seed));
        meas_set[1] <= 12'($random(seed));
        wr(8'h08, 16'h0001);
        wr(8'h09, {8'h00, ini});
        wr(8'h0A, {8'h00, hi});
        wr(8'h0B, {8'h00, lo});
        wr(`RTC_GLB_CTRL, 16'h0001);
        repeat (SCAN * 3) @(posedge core_clk);
        rd(8'h0F, d);
        chk_word("open loop hold", {8'h00, ini}, d);
        for (int j = 0; j < 3; j++) begin
            wr(`RTC_GLB_CMD, {8'h00, 4'h1, 2'b00, osel[j]});
            rd(8'h0F, d);
            chk_word("open loop margin", {6'h00, osel[j], (j == 2) ? lo : hi}, d);
            repeat (600) @(posedge core_clk);
            @(negedge core_clk);
            chk_word("pwm level", {8'h00, (j == 2) ? lo : hi}, {8'h00, trim_level[1]});
        end
        meas_set[3] <= 12'hFFF;
        wr(8'h18, 16'h0006);
        for (int s = 0; s < 3; s++) begin
            wr(`RTC_GLB_CMD, {8'h00, 4'h3, 2'b00, 2'(s)});
            @(negedge core_clk);
            chk_req({1'b1, 4'h3, 8'h01, (s == 1) ? 8'hA8 : (s == 2) ? 8'h98 : 8'h80},
                    pmbus_req);
        end
        wr(`RTC_GLB_CMD, 16'h0001);
        @(negedge core_clk);
        chk_req({1'b0, 4'h3, 8'h01, 8'h98}, pmbus_req);
        // Selection code 3 is refused: no pulse, margin of channel 3 kept
        wr(`RTC_GLB_CMD, 16'h0033);
        @(negedge core_clk);
        chk_req({1'b0, 4'h3, 8'h01, 8'h98}, pmbus_req);
        repeat (SCAN * 3) @(posedge core_clk);
        rd(8'h1F, d);
        chk_word("digital rail code", 16'h0280, d);
        rd(8'h07, d);
        chk_word("disabled rail code", 16'h0180, d);
        rd(8'h02, d);
        chk_word("untouched channel", 16'h00A0, d);
        report_and_stop;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        report_and_stop;
    end
endmodule

bind rtc_top rtc_properties #(.N(N)) u_props (.core_clk(core_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rail_meas(rail_meas), .rails_powered(rails_powered),
    .trim_pwm(trim_pwm), .pmbus_req(pmbus_req));
